//--- vsfw_pkg.sv
// Purpose: shared constants of the video standard flywheel
// Assumes: 32-bit AHB-Lite register slave, 20-bit word-aligned video input
// Notes: register offsets are byte addresses
package vsfw_pkg;
    localparam int STD_W = 4;
    localparam int INT_W = 3;
    localparam int MATCH_LINES = 3;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    localparam logic [3:0] OFS_INT_STATUS = 4'h8;
    localparam logic [3:0] OFS_INT_MASK = 4'hc;
    localparam int CTRL_FAST_EN = 0;
    localparam int STAT_LOCKED = 4;
    localparam int STAT_INTL = 5;
    localparam int INT_STD = 0;
    localparam int INT_EAV = 1;
    localparam int INT_SAV = 2;
    localparam logic CTRL_FAST_EN_RST = 1'b1;
    localparam logic [INT_W-1:0] INT_MASK_RST = 3'h0;
    // ------------------------------------------------------------
    // standard codes
    // ------------------------------------------------------------
    localparam logic [STD_W-1:0] STD_720P = 4'h0;
    localparam logic [STD_W-1:0] STD_1080P30 = 4'h2;
    localparam logic [STD_W-1:0] STD_1080P25 = 4'h4;
    localparam logic [STD_W-1:0] STD_1080P24 = 4'h6;
    localparam logic [STD_W-1:0] STD_UNK_P = 4'h7;
    localparam logic [STD_W-1:0] STD_1080I30 = 4'h8;
    localparam logic [STD_W-1:0] STD_1080I25 = 4'ha;
    localparam logic [STD_W-1:0] STD_1080I25_1250 = 4'hc;
    localparam logic [STD_W-1:0] STD_1035I = 4'he;
    localparam logic [STD_W-1:0] STD_UNK_I = 4'hf;
    localparam logic [STD_W-1:0] STD_RST = STD_UNK_P;
    localparam int LINES_750 = 750;
    localparam int LINES_1125 = 1125;
    localparam int LINES_1250 = 1250;
    localparam int ACT_1035 = 1035;
    localparam int ACT_1080 = 1080;
    localparam int WORDS_1650 = 1650;
    localparam int WORDS_2200 = 2200;
    localparam int WORDS_2376 = 2376;
    localparam int WORDS_2640 = 2640;
    localparam int WORDS_2750 = 2750;
    localparam int WORDS_RST = WORDS_2200;
    // ------------------------------------------------------------
    // timing reference word layout
    // ------------------------------------------------------------
    localparam logic [9:0] TRS_ONES = 10'h3ff;
    localparam logic [9:0] TRS_ZERO = 10'h000;
    localparam int XYZ_ONE = 9;
    localparam int XYZ_F = 8;
    localparam int XYZ_V = 7;
    localparam int XYZ_H = 6;
    localparam int XYZ_P3 = 5;
    localparam int XYZ_P2 = 4;
    localparam int XYZ_P1 = 3;
    localparam int XYZ_P0 = 2;
endpackage

//--- vsfw_trs_decode.sv
// Purpose: find timing reference words in the luma channel and decode H, V, F
// Assumes: word-aligned luma on the same clock
// Notes: outputs land one cycle after the xyz word
`timescale 1ns/1ns
module vsfw_trs_decode
(
    input wire logic hclk,    // pixel clock
    input wire logic hresetn, // async reset, low active
    input wire logic clk_en,  // freezes state when low
    input wire logic [9:0] luma, // luma word
    output logic trs_pulse,   // reference word seen
    output logic trs_h,       // decoded h
    output logic trs_v,       // decoded v
    output logic trs_f,       // decoded f
    output logic trs_err      // protection bits wrong
);
    import vsfw_pkg::*;

    logic [9:0] w1, w2, w3, next_w1, next_w2, next_w3;
    logic next_pulse, next_h, next_v, next_f, next_err;
    logic hit, f, v, h, bad;

    always_comb
    begin
        hit = (w3 == TRS_ONES) && (w2 == TRS_ZERO) && (w1 == TRS_ZERO);
        f = luma[XYZ_F];
        v = luma[XYZ_V];
        h = luma[XYZ_H];
        bad = !luma[XYZ_ONE] || (luma[XYZ_P3] != (v ^ h)) || (luma[XYZ_P2] != (f ^ h))
            || (luma[XYZ_P1] != (f ^ v)) || (luma[XYZ_P0] != (f ^ v ^ h));
        next_w1 = luma;
        next_w2 = w1;
        next_w3 = w2;
        next_pulse = hit;
        next_h = hit ? h : trs_h;
        next_v = hit ? v : trs_v;
        next_f = hit ? f : trs_f;
        next_err = hit && bad;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            w1 <= 10'h000;
            w2 <= 10'h000;
            w3 <= 10'h000;
            trs_pulse <= 1'b0;
            trs_h <= 1'b0;
            trs_v <= 1'b0;
            trs_f <= 1'b0;
            trs_err <= 1'b0;
        end
        else if (clk_en)
        begin
            w1 <= next_w1;
            w2 <= next_w2;
            w3 <= next_w3;
            trs_pulse <= next_pulse;
            trs_h <= next_h;
            trs_v <= next_v;
            trs_f <= next_f;
            trs_err <= next_err;
        end
    end
endmodule

//--- vsfw_flywheel.sv
// Purpose: video standard detection and H/V/F flywheel with AHB-Lite registers
// Assumes: word-aligned 20-bit video on hclk, luma in the upper half
// Notes: words per line are counted per channel, one word per clock
// ------------------------------------------------------------
// ------------------------------------------------------------
`timescale 1ns/1ns
module vsfw_flywheel
#(
    parameter int WW = 12, // word counter width
    parameter int LW = 11  // line counter width
)
(
    input wire logic hclk,            // pixel and bus clock
    input wire logic hresetn,         // async reset, low active
    input wire logic clk_en,          // freezes all state when low
    input wire logic [19:0] video_in, // luma [19:10], chroma [9:0]
    input wire logic fast_lock,       // switch line lock pin
    input wire logic hsel,            // ahb select
    input wire logic [31:0] haddr,    // ahb address
    input wire logic [1:0] htrans,    // ahb transfer type
    input wire logic hwrite,          // ahb write
    input wire logic [2:0] hsize,     // ahb size, words only
    input wire logic [31:0] hwdata,   // ahb write data
    input wire logic hready,          // ahb bus ready
    output logic hreadyout,           // ahb slave ready
    output logic [31:0] hrdata,       // ahb read data
    output logic hresp,               // ahb response, always okay
    output logic [vsfw_pkg::STD_W-1:0] video_standard_code, // detected standard
    output logic h_out,               // flywheel h
    output logic v_out,               // flywheel v
    output logic f_out,               // flywheel f
    output logic start_marker_error,  // start reference error pulse
    output logic end_marker_error,    // end reference error pulse
    output logic irq                  // level interrupt
);
    import vsfw_pkg::*;

    generate
        if (WW < 12 || LW < 11)
        begin : g_chk
            $error("vsfw_flywheel: counters too narrow");
        end
    endgenerate

    logic d_pulse, d_h, d_v, d_f, d_err;

    vsfw_trs_decode u_trs
    (
        .hclk(hclk),
        .hresetn(hresetn),
        .clk_en(clk_en),
        .luma(video_in[19:10]),
        .trs_pulse(d_pulse),
        .trs_h(d_h),
        .trs_v(d_v),
        .trs_f(d_f),
        .trs_err(d_err)
    );

    // ------------------------------------------------------------
    // flywheel and detection state
    // ------------------------------------------------------------
    logic fl_s1, fl_s2, fl_prev, fast_arm, locked, fw_v, fw_f, prev_v, seen_f1, started, intl;
    logic [WW-1:0] meas_cnt, sav_meas, cand_len, cand_sav, fw_len, fw_sav, fw_pos;
    logic [LW-1:0] line_cnt, act_cnt;
    logic [1:0] match_cnt;
    logic next_fl_s2, next_fl_prev, next_fast_arm, next_locked, next_fw_v, next_fw_f;
    logic next_prev_v, next_seen_f1, next_started, next_intl;
    logic [WW-1:0] next_meas, next_sav_meas, next_cand_len, next_cand_sav;
    logic [WW-1:0] next_fw_len, next_fw_sav, next_fw_pos;
    logic [LW-1:0] next_line_cnt, next_act_cnt;
    logic [1:0] next_match;
    logic [STD_W-1:0] next_std, new_std;
    logic next_h, next_v, next_f, next_sme, next_eme;
    logic eav, sav, good_eav, eav_ok, adopt, fast_hit, fl_rise, eff_v, eff_f;
    logic frame_start, frame_upd, frame_intl;
    logic [INT_W-1:0] ev;

    function automatic logic [STD_W-1:0] classify(input int lines, input int act,
                                                  input int words, input logic il);
        classify = il ? STD_UNK_I : STD_UNK_P;
        if (!il)
        begin
            if (lines == LINES_750 && words == WORDS_1650)
                classify = STD_720P;
            else if (lines == LINES_1125 && words == WORDS_2200)
                classify = STD_1080P30;
            else if (lines == LINES_1125 && words == WORDS_2640)
                classify = STD_1080P25;
            else if (lines == LINES_1125 && words == WORDS_2750)
                classify = STD_1080P24;
        end
        else
        begin
            if (lines == LINES_1125 && words == WORDS_2200 && act == ACT_1080)
                classify = STD_1080I30;
            else if (lines == LINES_1125 && words == WORDS_2200 && act == ACT_1035)
                classify = STD_1035I;
            else if (lines == LINES_1125 && words == WORDS_2640)
                classify = STD_1080I25;
            else if (lines == LINES_1250 && words == WORDS_2376)
                classify = STD_1080I25_1250;
        end
    endfunction

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic ctrl_fast_en, wr_sel, next_ctrl_fast_en, next_wr_sel, next_irq, addr_ok;
    logic [3:0] wr_addr, next_wr_addr;
    logic [INT_W-1:0] int_status, int_mask, next_int_status, next_int_mask;
    logic [31:0] next_hrdata, rd;

    always_comb
    begin
        eav = d_pulse && d_h;
        sav = d_pulse && !d_h;
        good_eav = eav && !d_err;
        eav_ok = good_eav && locked && (fw_pos == '0);
        fl_rise = fl_s2 && !fl_prev && ctrl_fast_en;
        // fast lock fixes h only, so v and f are left as they run
        fast_hit = fast_arm && good_eav;
        next_fl_s2 = fl_s1;
        next_fl_prev = fl_s2;
        next_fast_arm = fl_rise || (fast_arm && !fast_hit);
        next_meas = eav ? {{(WW-1){1'b0}}, 1'b1} : meas_cnt + 1'b1;
        next_sav_meas = sav ? meas_cnt : sav_meas;
        next_cand_len = cand_len;
        next_cand_sav = cand_sav;
        next_match = match_cnt;
        if (good_eav)
        begin
            next_cand_len = meas_cnt;
            next_cand_sav = sav_meas;
            if (meas_cnt == cand_len && sav_meas == cand_sav)
                next_match = (int'(match_cnt) == MATCH_LINES) ? match_cnt : match_cnt + 2'd1;
            else
                next_match = 2'd1;
        end
        adopt = good_eav && !eav_ok && (int'(next_match) == MATCH_LINES);
        next_fw_len = fw_len;
        next_fw_sav = fw_sav;
        next_fw_v = fw_v;
        next_fw_f = fw_f;
        next_locked = locked || adopt;
        if (adopt)
        begin
            next_fw_len = meas_cnt;
            next_fw_sav = sav_meas;
        end
        // a bad line keeps the stored v and f
        if (adopt || eav_ok)
        begin
            next_fw_v = d_v;
            next_fw_f = d_f;
        end
        if (adopt || fast_hit)
            next_fw_pos = {{(WW-1){1'b0}}, 1'b1};
        else if (fw_pos >= next_fw_len - 1'b1)
            next_fw_pos = '0;
        else
            next_fw_pos = fw_pos + 1'b1;
        next_h = next_fw_pos < next_fw_sav;
        next_v = next_fw_v;
        next_f = next_fw_f;
        // v and f may change at an end marker, so they are checked at the start marker
        next_eme = eav && (d_err || (locked && fw_pos != '0));
        next_sme = sav && (d_err || (locked && (fw_pos != fw_sav || d_v != fw_v
            || d_f != fw_f)));
        // frame measure: v rising with f low comes once per frame
        eff_v = eav_ok ? d_v : fw_v;
        eff_f = eav_ok ? d_f : fw_f;
        frame_start = eav && eff_v && !prev_v && !eff_f;
        frame_upd = frame_start && started;
        frame_intl = seen_f1 || eff_f;
        next_prev_v = eav ? eff_v : prev_v;
        next_started = started || frame_start;
        next_line_cnt = line_cnt;
        next_act_cnt = act_cnt;
        next_seen_f1 = seen_f1;
        if (frame_start)
        begin
            next_line_cnt = {{(LW-1){1'b0}}, 1'b1};
            next_act_cnt = '0;
            next_seen_f1 = 1'b0;
        end
        else if (eav)
        begin
            next_line_cnt = line_cnt + 1'b1;
            next_act_cnt = act_cnt + {{(LW-1){1'b0}}, !eff_v};
            next_seen_f1 = frame_intl;
        end
        new_std = classify(int'(line_cnt), int'(act_cnt), int'(fw_len), frame_intl);
        next_std = frame_upd ? new_std : video_standard_code;
        next_intl = frame_upd ? frame_intl : intl;
        // bus slave: zero wait, read data registered in the address phase
        addr_ok = hsel && hready && htrans[1];
        next_wr_sel = addr_ok && hwrite && (haddr[31:4] == 28'h0);
        next_wr_addr = haddr[3:0];
        rd = 32'h0;
        case (haddr[3:0])
            OFS_CTRL: rd[CTRL_FAST_EN] = ctrl_fast_en;
            OFS_STATUS:
            begin
                rd[STD_W-1:0] = video_standard_code;
                rd[STAT_LOCKED] = locked;
                rd[STAT_INTL] = intl;
            end
            OFS_INT_STATUS: rd[INT_W-1:0] = int_status;
            OFS_INT_MASK: rd[INT_W-1:0] = int_mask;
            default: rd = 32'h0;
        endcase
        if (haddr[31:4] != 28'h0)
            rd = 32'h0;
        next_hrdata = (addr_ok && !hwrite) ? rd : hrdata;
        ev = '0;
        ev[INT_STD] = frame_upd && (new_std != video_standard_code);
        ev[INT_EAV] = next_eme;
        ev[INT_SAV] = next_sme;
        next_ctrl_fast_en = ctrl_fast_en;
        next_int_mask = int_mask;
        next_int_status = int_status;
        if (wr_sel && wr_addr == OFS_CTRL)
            next_ctrl_fast_en = hwdata[CTRL_FAST_EN];
        if (wr_sel && wr_addr == OFS_INT_MASK)
            next_int_mask = hwdata[INT_W-1:0];
        if (wr_sel && wr_addr == OFS_INT_STATUS)
            next_int_status = int_status & ~hwdata[INT_W-1:0];
        // a new event wins over a clear in the same cycle
        next_int_status = next_int_status | ev;
        next_irq = |(next_int_status & next_int_mask);
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            fl_s1 <= 1'b0;
            fl_s2 <= 1'b0;
            fl_prev <= 1'b0;
            fast_arm <= 1'b0;
            meas_cnt <= '0;
            sav_meas <= '0;
            cand_len <= '0;
            cand_sav <= '0;
            match_cnt <= 2'd0;
            fw_len <= WW'(WORDS_RST);
            fw_sav <= '0;
            fw_pos <= '0;
            fw_v <= 1'b0;
            fw_f <= 1'b0;
            locked <= 1'b0;
            prev_v <= 1'b0;
            started <= 1'b0;
            line_cnt <= '0;
            act_cnt <= '0;
            seen_f1 <= 1'b0;
            intl <= 1'b0;
            video_standard_code <= STD_RST;
            h_out <= 1'b0;
            v_out <= 1'b0;
            f_out <= 1'b0;
            start_marker_error <= 1'b0;
            end_marker_error <= 1'b0;
            ctrl_fast_en <= CTRL_FAST_EN_RST;
            int_mask <= INT_MASK_RST;
            int_status <= '0;
            irq <= 1'b0;
            wr_sel <= 1'b0;
            wr_addr <= 4'h0;
            hrdata <= 32'h0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else if (clk_en)
        begin
            fl_s1 <= fast_lock;
            fl_s2 <= next_fl_s2;
            fl_prev <= next_fl_prev;
            fast_arm <= next_fast_arm;
            meas_cnt <= next_meas;
            sav_meas <= next_sav_meas;
            cand_len <= next_cand_len;
            cand_sav <= next_cand_sav;
            match_cnt <= next_match;
            fw_len <= next_fw_len;
            fw_sav <= next_fw_sav;
            fw_pos <= next_fw_pos;
            fw_v <= next_fw_v;
            fw_f <= next_fw_f;
            locked <= next_locked;
            prev_v <= next_prev_v;
            started <= next_started;
            line_cnt <= next_line_cnt;
            act_cnt <= next_act_cnt;
            seen_f1 <= next_seen_f1;
            intl <= next_intl;
            video_standard_code <= next_std;
            h_out <= next_h;
            v_out <= next_v;
            f_out <= next_f;
            start_marker_error <= next_sme;
            end_marker_error <= next_eme;
            ctrl_fast_en <= next_ctrl_fast_en;
            int_mask <= next_int_mask;
            int_status <= next_int_status;
            irq <= next_irq;
            wr_sel <= next_wr_sel;
            wr_addr <= next_wr_addr;
            hrdata <= next_hrdata;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    a_code_msb_intl: assert property (clk_en && frame_upd |=>
        video_standard_code[3] == $past(frame_intl)) else $error("code msb wrong");
    a_code_720p: assert property (clk_en && frame_upd && !frame_intl
        && int'(line_cnt) == LINES_750 && int'(fw_len) == WORDS_1650 |=>
        video_standard_code == STD_720P) else $error("720p code wrong");
    a_code_p25: assert property (clk_en && frame_upd && !frame_intl
        && int'(line_cnt) == LINES_1125 && int'(fw_len) == WORDS_2640 |=>
        video_standard_code == STD_1080P25) else $error("1080p25 code wrong");
    a_code_unk_p: assert property (clk_en && frame_upd && !frame_intl
        && int'(line_cnt) != LINES_750 && int'(line_cnt) != LINES_1125 |=>
        video_standard_code == STD_UNK_P) else $error("unknown p code wrong");
    a_code_i30: assert property (clk_en && frame_upd && frame_intl
        && int'(line_cnt) == LINES_1125 && int'(fw_len) == WORDS_2200
        && int'(act_cnt) == ACT_1080 |=> video_standard_code == STD_1080I30)
        else $error("1080i30 code wrong");
    a_code_1035i: assert property (clk_en && frame_upd && frame_intl
        && int'(line_cnt) == LINES_1125 && int'(fw_len) == WORDS_2200
        && int'(act_cnt) == ACT_1035 |=> video_standard_code == STD_1035I)
        else $error("1035i code wrong");
    a_code_unk_i: assert property (clk_en && frame_upd && frame_intl
        && int'(line_cnt) != LINES_1125 && int'(line_cnt) != LINES_1250 |=>
        video_standard_code == STD_UNK_I) else $error("unknown i code wrong");
    a_lines_1250: assert property (clk_en && frame_upd && int'(line_cnt) != LINES_1250
        |=> video_standard_code != STD_1080I25_1250) else $error("1250 code wrong");
    a_sync_valid: assert property (clk_en && eav_ok && !fast_hit |=>
        fw_pos == WW'(1) && fw_v == $past(d_v) && !end_marker_error) else $error("lost sync");
    a_hold_invalid: assert property (clk_en && eav && !eav_ok && !adopt |=>
        $stable(fw_v) && $stable(fw_f) && $stable(fw_len)) else $error("bad line used");
    a_adopt_three: assert property (clk_en && adopt |=> locked
        && fw_len == $past(meas_cnt) && match_cnt == 2'd3)
        else $error("adopt wrong");
    a_eav_mismatch: assert property (clk_en && eav && locked && fw_pos != '0 |=>
        end_marker_error) else $error("end error missing");
    a_fast_align: assert property (clk_en && fast_hit |=> fw_pos == WW'(1) && !fast_arm)
        else $error("fast lock not aligned");
    a_sav_error: assert property (clk_en && sav && (d_err || (locked && fw_pos != fw_sav))
        |=> start_marker_error) else $error("start error missing");
    a_no_reserved: assert property (video_standard_code[0] |->
        video_standard_code[2:1] == 2'b11) else $error("reserved code");

    c_adopt: cover property (clk_en && adopt);
    c_fast: cover property (clk_en && fast_hit);
    c_std_change: cover property (clk_en && ev[INT_STD]);
    c_irq: cover property (irq && start_marker_error);
endmodule

//--- vsfw_src.sv
// Purpose: upstream source model sending word-aligned video with timing words
// Assumes: LEN words a line, NL lines a frame, one word a clock
// Notes: bad spoils one parity bit of both timing words of the next line
`timescale 1ns/1ns
module vsfw_src
#(
    parameter int LEN = 40, // words per line
    parameter int SAV = 8,  // start marker offset
    parameter int NL = 8    // lines per frame
)
(
    input wire logic hclk,       // pixel clock
    input wire logic hresetn,    // reset, low active
    input wire logic il,         // interlaced frames
    input wire logic bad,        // spoil next line
    input wire logic slip,       // repeat the current word, shifting h
    input wire logic [9:0] fill, // filler luma, never a marker code
    output logic [19:0] video    // word to the block
);
    int pos, ln;
    logic bq, f, v, h;
    logic [9:0] y;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pos <= 0;
            ln <= 0;
            bq <= 1'b0;
        end
        else if (!slip && pos == LEN - 1)
        begin
            pos <= 0;
            ln <= (ln == NL - 1) ? 0 : ln + 1;
            bq <= bad;
        end
        else if (!slip)
            pos <= pos + 1;
    end
    // second half of an interlaced frame is field two; v covers two lines per field
    always_comb
    begin
        f = il && ln >= NL / 2;
        v = (ln % (il ? NL / 2 : NL)) < 2;
        h = pos < SAV;
        y = fill;
        if (pos == 0 || pos == SAV)
            y = 10'h3ff;
        if (pos == 1 || pos == 2 || pos == SAV + 1 || pos == SAV + 2)
            y = 10'h000;
        if (pos == 3 || pos == SAV + 3)
            y = {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h ^ bq, 2'h0};
        video = {y, ~y};
    end
endmodule

//--- testbench.sv
// Purpose: self-checking bench of the video standard flywheel
// Assumes: source model with 40-word lines and 8-line frames
// Notes: real formats take millions of cycles, so only unknown codes are reached
`timescale 1ns/1ns
module testbench;
    import vsfw_pkg::*;
    localparam int LEN = 40;
    localparam int SAV = 8;
    logic hclk, hresetn, il, bad, slip, fl, hsel, hwrite, rdy, irq, h, se, ee;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, rd, mask;
    logic [19:0] video;
    logic [9:0] fill;
    logic [3:0] code;
    int n_fail, checked, seed, k, nh, ns, ne;
    vsfw_src #(.LEN(LEN), .SAV(SAV), .NL(8)) src (.hclk(hclk), .hresetn(hresetn),
        .il(il), .bad(bad), .slip(slip), .fill(fill), .video(video));
    vsfw_flywheel DUT (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .video_in(video),
        .fast_lock(fl), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(rdy), .hreadyout(rdy), .hrdata(hrdata),
        .hresp(), .video_standard_code(code), .h_out(h), .v_out(), .f_out(),
        .start_marker_error(se), .end_marker_error(ee), .irq(irq));
    initial
    begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end
    always @(posedge hclk)
        fill <= {2'h1, 8'($random(seed))};
    function automatic logic [3:0] exp_code(input logic i);
        return i ? STD_UNK_I : STD_UNK_P;
    endfunction
    function automatic logic exp_irq(input logic [31:0] st, input logic [31:0] mk);
        return |(st & mk & 32'h7);
    endfunction
    // ------
    // bus and check tasks
    // ------
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic stop();
        n_fail++;
        $display("BAD %0t wait ran out", $time);
        print_verdict();
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick();
        for (k = 0; k < 20; k++)
        begin
            @(posedge hclk);
            if (rdy === 1'b1)
                return;
        end
        stop();
    endtask
    // read data is taken at the closing edge, before that edge's updates land
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        tick();
        htrans <= 2'h0;
        hwdata <= d;
        tick();
        rd = hrdata;
    endtask
    task automatic wait_msb(input logic b);
        for (k = 0; k < 5000 && code[3] !== b; k++)
            @(posedge hclk);
        if (k == 5000)
            stop();
        chk(code, exp_code(b));
    endtask
    task automatic cycles(input int n);
        repeat (n)
        begin
            @(posedge hclk);
            nh += int'(h === 1'b1);
            ns += int'(se === 1'b1);
            ne += int'(ee === 1'b1);
        end
    endtask
    initial
    begin
        seed = 32'h78654292;
        {hresetn, il, bad, slip, fl, hsel, hwrite} = 7'h0;
        {htrans, haddr, hwdata} = 0;
        {n_fail, checked} = 0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        ahb(0, OFS_CTRL, 0);
        chk(rd, {31'h0, CTRL_FAST_EN_RST});
        ahb(0, OFS_INT_MASK, 0);
        chk(rd, {29'h0, INT_MASK_RST});
        ahb(0, OFS_STATUS, 0);
        chk(rd[3:0], STD_RST);
        ahb(1, 32'h40, 32'hffffffff);
        ahb(0, 32'h40, 0);
        chk(rd, 0);
        il <= 1'b1;
        wait_msb(1'b1);
        ahb(0, OFS_STATUS, 0);
        chk(rd[5:0], {2'h3, exp_code(1'b1)});
        mask = {29'h0, 1'b1, fill[1:0]};
        ahb(1, OFS_INT_STATUS, 32'h7);
        ahb(1, OFS_INT_MASK, mask);
        {nh, ns, ne} = 0;
        bad <= 1'b1;
        cycles(LEN);
        bad <= 1'b0;
        cycles(3 * LEN);
        chk(nh, 4 * SAV);
        chk(ne, 1);
        chk(ns, 1);
        ahb(0, OFS_INT_STATUS, 0);
        chk(rd & 32'h6, 32'h6);
        chk(irq, exp_irq(rd, mask));
        ahb(1, OFS_INT_STATUS, rd);
        ahb(0, OFS_INT_STATUS, 0);
        chk(irq, exp_irq(rd, mask));
        // a stalled source moves h; fast lock must realign within one line
        slip <= 1'b1;
        repeat (5) @(posedge hclk);
        slip <= 1'b0;
        fl <= 1'b1;
        cycles(2 * LEN);
        fl <= 1'b0;
        {nh, ns, ne} = 0;
        cycles(2 * LEN);
        chk(nh, 2 * SAV);
        chk(ne + ns, 0);
        il <= 1'b0;
        wait_msb(1'b0);
        print_verdict();
    end
endmodule
